/* File: design/ospt_pkg.sv */
/*
 * ospt_pkg: constants, register map, field layouts and types for the
 * single-pulse and pulse-train timer output block.
 * Assumes a 20 MHz system clock and a plain register port.
 */
package ospt_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ = 20;
	localparam int MCLK_NS = 1000 / CLK_MHZ;
	localparam int STEP_SCALE = 2000;
	localparam int REF_MHZ = 10;
	// mclk cycles per base step at clock select 0
	localparam int STD_CYC = STEP_SCALE / CLK_MHZ / MCLK_NS;
	localparam int EXT_CYC = STEP_SCALE / REF_MHZ / MCLK_NS;
	localparam logic [4:0] STD_SHIFT = 5'($clog2(STD_CYC));
	localparam logic [4:0] EXT_SHIFT = 5'($clog2(EXT_CYC));
	localparam int TRAIN_PERIOD = 256;
	localparam logic [7:0] HALF_LAST = 8'((TRAIN_PERIOD / 2) - 1);
	localparam logic [7:0] PERIOD_LAST = 8'(TRAIN_PERIOD - 1);

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CLKSEL = 4'h1;
	localparam logic [3:0] OFS_LOAD = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;
	localparam logic [3:0] OFS_REMAIN = 4'h4;
	localparam logic [3:0] OFS_IRQ_STAT = 4'h5;
	localparam logic [3:0] OFS_IRQ_CLR = 4'h6;
	localparam logic [3:0] OFS_IRQ_EN = 4'h7;

	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [3:0] SHOT_DEF_CLK = 4'h0;
	localparam logic [3:0] TRAIN_DEF_CLK = 4'h7;

	localparam int IRQ_W = 3;
	localparam int IRQ_SHOT_DONE = 0;
	localparam int IRQ_TRAIN_DONE = 1;
	localparam int IRQ_RETRIG = 2;

	localparam int ST_BUSY = 0;
	localparam int ST_LEVEL = 1;
	localparam int ST_TRAIN = 2;

	// control word layout, bit 0 at the bottom
	typedef struct packed {
		logic [3:0] cfg_clk;
		logic [1:0] rsvd;
		logic cfg_clk_ok;
		logic ext_range;
		logic pin_sel;
		logic init_level;
		logic invert;
		logic mode_train;
	} ospt_ctrl_t;

	typedef enum logic [2:0] {
		OSPT_IDLE = 3'b001,
		OSPT_SHOT = 3'b010,
		OSPT_TRAIN = 3'b100
	} ospt_state_t;

endpackage : ospt_pkg

/* File: design/ospt_prescale.sv */
/*
 * ospt_prescale: free-running power-of-two divider that gives a one
 * cycle base tick every 2^shift mclk cycles.
 * Assumes shift is held steady by the caller between changes.
 */
`timescale 1ns/10ps
module ospt_prescale import ospt_pkg::*; #(
	parameter int CNT_W = 18
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// divider control
	input wire logic [4:0] shift,
	// base tick
	output logic tick
);

	// ****************************************************************
	// divider
	// ****************************************************************
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] mask;

	generate
		if (CNT_W < 18) begin : g_chk
			$error("ospt_prescale: CNT_W too small for slowest select");
		end
	endgenerate

	// low shift bits all ones marks the step end
	assign mask = CNT_W'((CNT_W+1)'(1) << shift) - CNT_W'(1);
	assign tick = ((cnt_ff & mask) == mask);

	// free-running count, never restarted, so phase error stays < 1 tick
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= cnt_ff + CNT_W'(1);
		end
	end

endmodule : ospt_prescale

/* File: design/ospt_timer.sv */
/*
 * ospt_timer: retriggerable single-pulse and counted pulse-train output
 * on one of two pins, with a register port and a level interrupt.
 * Assumes a 20 MHz mclk and a master that waits for the train to end.
 */
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module ospt_timer import ospt_pkg::*; #(
	parameter int DATA_W = 16,
	parameter int PIN_N = 2,
	parameter bit EXT_RANGE_EN = 1'b1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// output pins
	output logic [PIN_N-1:0] out_pin,
	// interrupt
	output logic irq
);

	generate
		if (DATA_W != 16 || PIN_N != 2) begin : g_chk
			$error("ospt_timer: only 16-bit data and two pins supported");
		end
	endgenerate

	// ****************************************************************
	// register decode
	// ****************************************************************
	logic wr_ctrl;
	logic wr_clk;
	logic wr_load;
	logic wr_iclr;
	logic wr_ien;
	assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
	assign wr_clk = reg_wr && (reg_addr == OFS_CLKSEL);
	assign wr_load = reg_wr && (reg_addr == OFS_LOAD);
	assign wr_iclr = reg_wr && (reg_addr == OFS_IRQ_CLR);
	assign wr_ien = reg_wr && (reg_addr == OFS_IRQ_EN);

	ospt_ctrl_t ctrl_ff;
	logic [3:0] rt_clk_ff;
	logic rt_ok_ff;
	logic [DATA_W-1:0] load_ff;
	logic [IRQ_W-1:0] istat_ff;
	logic [IRQ_W-1:0] ien_ff;
	logic [DATA_W-1:0] rdata_ff;

	// ****************************************************************
	// clock select
	// ****************************************************************
	logic [3:0] def_clk;
	logic [3:0] raw_clk;
	logic [3:0] eff_clk;
	logic ext_on;
	logic [4:0] shift;
	logic tick;

	assign def_clk = ctrl_ff.mode_train ? TRAIN_DEF_CLK : SHOT_DEF_CLK;
	assign raw_clk = rt_ok_ff ? rt_clk_ff :
		(ctrl_ff.cfg_clk_ok ? ctrl_ff.cfg_clk : def_clk);
	assign ext_on = EXT_RANGE_EN && ctrl_ff.ext_range;
	// standard range keeps three bits, extended keeps four
	assign eff_clk = ext_on ? raw_clk : {1'b0, raw_clk[2:0]};
	assign shift = 5'(eff_clk) + (ext_on ? EXT_SHIFT : STD_SHIFT);

	ospt_prescale u_pre (
		.mclk(mclk),
		.nrst(nrst),
		.shift(shift),
		.tick(tick)
	);

	// ****************************************************************
	// sequencing
	// ****************************************************************
	ospt_state_t state_ff;
	ospt_state_t nxt_state;
	logic [DATA_W-1:0] cnt_ff;
	logic [DATA_W-1:0] nxt_cnt;
	logic [7:0] phase_ff;
	logic [7:0] nxt_phase;
	logic level_ff;
	logic nxt_level;
	logic [IRQ_W-1:0] ev;
	logic act_lvl;
	logic idle_lvl;
	logic shot_end;
	logic half_end;
	logic per_end;
	logic train_end;
	logic busy;

	assign act_lvl = ~ctrl_ff.invert;
	assign idle_lvl = ctrl_ff.invert;
	assign busy = (state_ff != OSPT_IDLE);
	assign shot_end = (state_ff == OSPT_SHOT) && tick &&
		(cnt_ff == load_ff - DATA_W'(1));
	assign half_end = (state_ff == OSPT_TRAIN) && tick &&
		(phase_ff == HALF_LAST);
	assign per_end = (state_ff == OSPT_TRAIN) && tick &&
		(phase_ff == PERIOD_LAST);
	assign train_end = per_end && (cnt_ff == DATA_W'(1));

	// next state, count, phase and pin level
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_phase = phase_ff;
		nxt_level = level_ff;
		ev = '0;
		if (wr_ctrl) begin
			nxt_state = OSPT_IDLE;
			nxt_level = reg_wdata[2];
		end else if (wr_load) begin
			ev[IRQ_RETRIG] = busy;
			nxt_cnt = ctrl_ff.mode_train ? reg_wdata : '0;
			nxt_phase = '0;
			if (reg_wdata == '0) begin
				nxt_state = OSPT_IDLE;
				nxt_level = ctrl_ff.mode_train ? idle_lvl : 1'b0;
			end else begin
				nxt_state = ctrl_ff.mode_train ? OSPT_TRAIN : OSPT_SHOT;
				nxt_level = act_lvl;
			end
		end else begin
			unique case (state_ff)
				OSPT_IDLE: begin
				end
				OSPT_SHOT: begin
					if (shot_end) begin
						nxt_state = OSPT_IDLE;
						nxt_level = idle_lvl;
						ev[IRQ_SHOT_DONE] = 1'b1;
					end else if (tick) begin
						nxt_cnt = cnt_ff + DATA_W'(1);
					end
				end
				OSPT_TRAIN: begin
					if (tick) begin
						nxt_phase = phase_ff + 8'h01;
					end
					if (half_end) begin
						nxt_level = idle_lvl;
					end
					if (train_end) begin
						nxt_state = OSPT_IDLE;
						ev[IRQ_TRAIN_DONE] = 1'b1;
					end else if (per_end) begin
						nxt_cnt = cnt_ff - DATA_W'(1);
						nxt_level = act_lvl;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= OSPT_IDLE;
			cnt_ff <= '0;
			phase_ff <= '0;
			level_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			phase_ff <= nxt_phase;
			level_ff <= nxt_level;
		end
	end

	// ****************************************************************
	// pin routing
	// ****************************************************************
	logic [PIN_N-1:0] nxt_pin;
	logic [PIN_N-1:0] pin_ff;
	logic [0:0] nxt_sel;
	assign nxt_sel = wr_ctrl ? reg_wdata[3] : ctrl_ff.pin_sel;

	// unselected pin is parked at 0
	generate
		for (genvar i = 0; i < PIN_N; i++) begin : g_pin
			assign nxt_pin[i] = (nxt_sel == 1'(i)) ? nxt_level : 1'b0;
		end
	endgenerate

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_ff <= '0;
		end else begin
			pin_ff <= nxt_pin;
		end
	end
	assign out_pin = pin_ff;

	// ****************************************************************
	// registers
	// ****************************************************************
	// config and run-time select; init write drops the override
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_ff <= CTRL_RST;
			rt_clk_ff <= SHOT_DEF_CLK;
			rt_ok_ff <= 1'b0;
			load_ff <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= ospt_ctrl_t'(reg_wdata[11:0] & 12'hF3F);
				rt_ok_ff <= 1'b0;
			end else if (wr_clk) begin
				rt_clk_ff <= reg_wdata[3:0];
				rt_ok_ff <= 1'b1;
			end
			if (wr_load) begin
				load_ff <= reg_wdata;
			end
		end
	end

	// sticky events, a set beats a clear in the same cycle
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			istat_ff <= '0;
			ien_ff <= '0;
		end else begin
			istat_ff <= ev | (istat_ff & ~(wr_iclr ? reg_wdata[IRQ_W-1:0] : '0));
			if (wr_ien) begin
				ien_ff <= reg_wdata[IRQ_W-1:0];
			end
		end
	end
	assign irq = |(istat_ff & ien_ff);

	// read mux, unmapped and write-only offsets read zero
	logic [DATA_W-1:0] rd_mux;
	logic [DATA_W-1:0] st_word;
	assign st_word = DATA_W'({ctrl_ff.mode_train, level_ff, busy});
	assign rd_mux =
		(reg_addr == OFS_CTRL) ? DATA_W'(ctrl_ff) :
		(reg_addr == OFS_CLKSEL) ? DATA_W'(eff_clk) :
		(reg_addr == OFS_LOAD) ? load_ff :
		(reg_addr == OFS_STATUS) ? st_word :
		(reg_addr == OFS_REMAIN) ? cnt_ff :
		(reg_addr == OFS_IRQ_STAT) ? DATA_W'(istat_ff) :
		(reg_addr == OFS_IRQ_EN) ? DATA_W'(ien_ff) : '0;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : '0;
		end
	end
	assign reg_rdata = rdata_ff;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence shot_load_s;
		wr_load && !ctrl_ff.mode_train && (reg_wdata != '0);
	endsequence

	sequence train_last_s;
		train_end && !wr_load && !wr_ctrl;
	endsequence

	shot_start_a: assert property (shot_load_s |=>
		(state_ff == OSPT_SHOT) && (level_ff == act_lvl) && (cnt_ff == '0))
		else $error("single pulse did not start active");

	zero_shot_a: assert property (wr_load && !ctrl_ff.mode_train &&
		(reg_wdata == '0) |=> (state_ff == OSPT_IDLE) && !level_ff)
		else $error("zero load did not force low");

	retrig_a: assert property (shot_load_s and (state_ff == OSPT_SHOT)
		|=> istat_ff[IRQ_RETRIG] && (cnt_ff == '0) && $stable(level_ff))
		else $error("retrigger did not restart timing");

	shot_end_a: assert property (shot_end && !wr_load && !wr_ctrl |=>
		(state_ff == OSPT_IDLE) && (level_ff == idle_lvl) &&
		istat_ff[IRQ_SHOT_DONE])
		else $error("single pulse did not end at count");

	shift_a: assert property (!ext_on |->
		shift == 5'({1'b0, eff_clk[2:0]}) + 5'h01)
		else $error("standard step is not two mclk cycles");

	clk_sel_a: assert property (wr_clk |=> rt_ok_ff &&
		(rt_clk_ff == $past(reg_wdata[3:0])))
		else $error("run-time clock select not taken");

	clk_def_a: assert property (!rt_ok_ff && !ctrl_ff.cfg_clk_ok |->
		(eff_clk == (ctrl_ff.mode_train ? 4'h7 : 4'h0)))
		else $error("default clock select wrong");

	half_a: assert property (half_end && !wr_load && !wr_ctrl |=>
		(level_ff == idle_lvl) && (state_ff == OSPT_TRAIN))
		else $error("train half period did not go idle");

	train_done_a: assert property (train_last_s |=>
		(state_ff == OSPT_IDLE) && istat_ff[IRQ_TRAIN_DONE] && !busy)
		else $error("train not reported complete");

	train_zero_a: assert property (wr_load && ctrl_ff.mode_train &&
		(reg_wdata == '0) |=> !busy && (level_ff == idle_lvl))
		else $error("zero count train not idle");

	init_lvl_a: assert property (wr_ctrl |=>
		(level_ff == $past(reg_wdata[2])) && !busy ##1
		(out_pin[ctrl_ff.pin_sel] == level_ff))
		else $error("initial level not applied");

	pin_route_a: assert property (1'b1 |=>
		out_pin[~ctrl_ff.pin_sel] == 1'b0)
		else $error("unselected pin not parked");

endmodule : ospt_timer

/* File: tb/ospt_load_model.sv */
/*
 * ospt_load_model: external pulse counter on the selected output pin.
 * Assumes the pin is sampled on mclk and inv gives the idle level.
 */
`timescale 1ns/10ps
module ospt_load_model (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// watched pin
	input wire logic pin,
	input wire logic inv,
	// measurements
	output logic [31:0] pulse_cnt,
	output logic [31:0] last_width,
	output logic [31:0] last_gap
);
	logic [31:0] run_ff;
	logic act_ff;
	wire act = pin ^ inv; // active level
	// count active runs and the idle gaps between them
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pulse_cnt <= '0;
			last_width <= '0;
			last_gap <= '0;
			run_ff <= '0;
			act_ff <= 1'b0;
		end else begin
			act_ff <= act;
			run_ff <= (act != act_ff) ? 32'h1 : run_ff + 32'h1;
			if (act_ff && !act) begin
				pulse_cnt <= pulse_cnt + 32'h1;
				last_width <= run_ff;
			end
			if (!act_ff && act)
				last_gap <= run_ff;
		end
	end
endmodule : ospt_load_model

/* File: tb/ospt_timer_tb.sv */
/*
 * ospt_timer_tb: random and corner tests of the pulse and train timer.
 * Assumes a 20 MHz mclk and the register map of ospt_pkg.
 */
`timescale 1ns/10ps
module ospt_timer_tb import ospt_pkg::*;;
	logic mclk, nrst, reg_wr, reg_rd, psel, inv;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [1:0] out_pin;
	logic irq;
	logic [31:0] pulse_cnt, last_width, last_gap, c, n;
	bit b;
	int err_count = 0;
	int n_compared = 0;
	wire pin_w = out_pin[psel];

	ospt_timer u_ospt_timer (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .out_pin(out_pin), .irq(irq));
	ospt_load_model u_ospt_load_model (.mclk(mclk), .nrst(nrst), .pin(pin_w),
		.inv(inv), .pulse_cnt(pulse_cnt), .last_width(last_width),
		.last_gap(last_gap));

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic int tick_cyc(input int sel, input bit ext);
		tick_cyc = STEP_SCALE * (1 << sel) / (ext ? REF_MHZ : CLK_MHZ) / MCLK_NS;
	endfunction : tick_cyc

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic chk_rng(input string nm, input int lo, input int hi,
		input logic [31:0] g);
		n_compared++;
		if ($isunknown(g) || g < lo || g > hi) begin
			err_count++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_rng

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	// initialise the channel and let the pin settle
	task automatic cfg(input bit md, input bit iv, input bit ps, input bit ext,
		input bit init, input logic [3:0] clk);
		ospt_ctrl_t cw;
		cw = '0;
		cw.mode_train = md;
		cw.invert = iv;
		cw.pin_sel = ps;
		cw.ext_range = ext;
		cw.init_level = init;
		cw.cfg_clk = clk;
		cw.cfg_clk_ok = |clk;
		wr(OFS_CTRL, 16'(cw));
		// same edge as the pin update, so the model sees no false edge
		psel <= ps;
		inv <= iv;
		repeat (3) @(posedge mclk);
	endtask : cfg

	task automatic wait_pulse(input logic [31:0] c0, input int lim);
		for (int k = 0; k < lim; k++) begin
			@(posedge mclk);
			if (pulse_cnt !== c0)
				break;
		end
		#1 chk("pulse seen", c0 + 1, pulse_cnt);
	endtask : wait_pulse

	task automatic shot(input int nn, input int t);
		c = pulse_cnt;
		wr(OFS_LOAD, 16'(nn));
		#1 chk("other pin", 0, out_pin[~psel]);
		wait_pulse(c, nn * t + 20);
		chk_rng("shot width", (nn - 1) * t, nn * t + 2, last_width);
		chk("shot idle", inv, pin_w);
	endtask : shot

	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	// ****************************************************************
	// clock, watchdog and tests
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (60000) @(posedge mclk);
		err_count++;
		results();
	end

	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		psel = 1'b0;
		inv = 1'b0;
		void'($urandom(32'h6aeec20c));
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		chk("pin reset", 0, out_pin);
		rd(OFS_CTRL, d);
		chk("ctrl reset", 0, d);
		rd(OFS_CLKSEL, d);
		chk("clock default", 0, d);
		rd(4'hF, d);
		chk("unmapped", 0, d);
		cfg(0, 0, 1, 0, 1, 0);
		chk("init level", 2'b10, out_pin);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			n = 1 + $urandom % 24;
			// initial level equal to the idle level of the chosen polarity
			b = 1'($urandom);
			cfg(0, b, 1'($urandom), 0, b, 0);
			shot(n, tick_cyc(0, 0));
		end
		$display("test random shots done");
		cfg(0, 0, 0, 0, 0, 3);
		shot(3, tick_cyc(3, 0));
		wr(OFS_CLKSEL, 16'h2);
		rd(OFS_CLKSEL, d);
		chk("run clock", 2, d);
		shot(5, tick_cyc(2, 0));
		cfg(0, 0, 0, 1, 0, 0);
		wr(OFS_CLKSEL, 16'h9);
		shot(2, tick_cyc(9, 1));
		$display("test clock select done");
		cfg(0, 0, 0, 0, 0, 0);
		wr(OFS_IRQ_CLR, 16'h7);
		wr(OFS_IRQ_EN, 16'h7);
		c = pulse_cnt;
		wr(OFS_LOAD, 16'd10);
		repeat (8) @(posedge mclk);
		wr(OFS_LOAD, 16'd20);
		wait_pulse(c, 80);
		chk_rng("retrigger width", 46, 54, last_width);
		rd(OFS_IRQ_STAT, d);
		chk("irq status", 3'b101, d);
		chk("irq on", 1, irq);
		wr(OFS_IRQ_CLR, 16'h7);
		#1 chk("irq cleared", 0, irq);
		wr(OFS_IRQ_EN, 16'h0);
		shot(1, tick_cyc(0, 0));
		chk("irq masked", 0, irq);
		$display("test retrigger done");
		cfg(0, 1, 1, 0, 1, 0);
		chk("invert idle", 2'b10, out_pin);
		wr(OFS_LOAD, 16'h0);
		#1 chk("zero load", 0, out_pin);
		$display("test zero shot done");
		b = 1'($urandom);
		cfg(1, b, 1'($urandom), 0, b, 0);
		wr(OFS_CLKSEL, 16'h1);
		c = pulse_cnt;
		wr(OFS_LOAD, 16'h3);
		rd(OFS_REMAIN, d);
		chk("train remain", 3, d);
		for (int k = 0; k < 3000; k++) begin
			rd(OFS_STATUS, d);
			if (d[ST_BUSY] === 1'b0)
				break;
		end
		chk("train count", c + 3, pulse_cnt);
		chk("train high", 128 * tick_cyc(1, 0), last_width);
		chk("train period", 256 * tick_cyc(1, 0), last_width + last_gap);
		rd(OFS_IRQ_STAT, d);
		chk("train done", 1, d[IRQ_TRAIN_DONE]);
		chk("train idle", 2'(inv) << psel, out_pin);
		cfg(1, 1, 0, 0, 0, 0);
		wr(OFS_CLKSEL, 16'h1);
		c = pulse_cnt;
		wr(OFS_LOAD, 16'h0);
		repeat (20) @(posedge mclk);
		// the pin leaves its low initial level once, then stays idle
		chk("zero train", c + 1, pulse_cnt);
		chk("zero idle", 2'b01, out_pin);
		rd(OFS_STATUS, d);
		chk("zero busy", 0, d[ST_BUSY]);
		$display("test train done");
		results();
	end
endmodule : ospt_timer_tb
